/* File: hdl/cgu_pkg.sv */
package cgu_pkg;

    ////////////////////////////////////////////////////////////////////////
    // register map, byte addresses of the low address byte
    localparam logic [7:0] OFF_CTRL  = 8'h00;
    localparam logic [7:0] OFF_DIV   = 8'h04;
    localparam logic [7:0] OFF_RANGE = 8'h08;
    localparam logic [7:0] OFF_STAT  = 8'h0C;
    localparam logic [7:0] OFF_ISTAT = 8'h10;
    localparam logic [7:0] OFF_IMASK = 8'h14;

    ////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int DIV_R_POS   = 16;
    localparam int RANGE_E_POS = 8;

    ////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [5:0]  CTRL_RST  = 6'h04;
    localparam int          N_RST     = 1;
    localparam int          R_RST     = 1;
    localparam logic [7:0]  L_RST     = 8'h01;
    localparam logic [1:0]  E_RST     = 2'h0;
    localparam logic [31:0] RDATA_RST = 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////
    // counts
    localparam int LOCK_CW    = 16;
    localparam int F_NOM_HZ   = 71_400;
    localparam int CLK_HZ     = 125_000_000;

    typedef struct packed {
        logic sys_xtal;
        logic run_stop;
        logic man_trk;
        logic auto_md;
        logic pll_en;
        logic sel_vco;
    } cgu_ctrl_t;

    typedef struct packed {
        logic fast;
        logic up;
        logic dn;
    } cgu_pump_t;

    typedef enum logic [1:0] {
        MD_ACQ = 2'b01,
        MD_TRK = 2'b10
    } cgu_mode_t;

endpackage

/* File: hdl/cgu_top.sv */
// Design decisions made here: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
module cgu_top #(
    parameter int NW       = 8,
    parameter int LOCK_WIN = 64,
    parameter int LOCK_TOL = 2
) (
    input  wire logic              clk_in,
    input  wire logic              arst_n_in,
    input  wire logic              ce_in,
    input  wire logic              hsel_in,
    input  wire logic [31:0]       haddr_in,
    input  wire logic [1:0]        htrans_in,
    input  wire logic              hwrite_in,
    input  wire logic [2:0]        hsize_in,
    input  wire logic [31:0]       hwdata_in,
    input  wire logic              hready_in,
    output logic                   hreadyout_out,
    output logic                   hresp_out,
    output logic [31:0]            hrdata_out,
    input  wire logic              crystal_clock_in,
    input  wire logic              vco_clock_in,
    input  wire logic              sysint_osc_enable_in,
    output logic                   osc_enable_out,
    output logic                   pll_reference_clock_out,
    output logic                   final_reference_clock_out,
    output logic                   vco_feedback_clock_out,
    output logic                   base_clock_out,
    output logic                   bus_clock_out,
    output logic                   sys_clock_out,
    output cgu_pkg::cgu_pump_t     pump_out,
    output logic [7:0]             vco_lin_out,
    output logic [1:0]             vco_exp_out,
    output logic                   locked_out,
    output logic                   tracking_out,
    output logic                   irq_out
);
    import cgu_pkg::*;

    function automatic logic [NW-1:0] div_top(input logic [NW-1:0] n);
        div_top = (n == '0) ? '0 : n - 1'b1;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // declarations
    logic            wr_q, wr_d;
    logic [7:0]      waddr_q, waddr_d;
    logic [31:0]     rdata_q, rdata_d;
    cgu_ctrl_t       ctrl_q, ctrl_d;
    logic [NW-1:0]   ndiv_q, ndiv_d, rdiv_q, rdiv_d;
    logic [7:0]      lin_q, lin_d;
    logic [1:0]      exp_q, exp_d;
    logic            imask_q, imask_d;
    logic            xs_q, vs_q, base_q, base_d, bus_q, bus_d, sys_q, sys_d, osc_q, osc_d;
    logic [NW-1:0]   fbcnt_q, fbcnt_d, rfcnt_q, rfcnt_d;
    logic            fbp_q, fbp_d, rfp_q, rfp_d, fbclk_q, fbclk_d, rfclk_q, rfclk_d;
    logic            x_re, v_re, sel_re;
    logic            up_q, up_d, dn_q, dn_d, lock_q, lock_d, ist_q, ist_d, irq_q, irq_d;
    logic [LOCK_CW-1:0] win_q, win_d, fcnt_q, fcnt_d, fsum;
    cgu_mode_t       mode_q, mode_d;
    logic            go_trk;

    ////////////////////////////////////////////////////////////////////////
    // ahb-lite slave: zero wait states, read data taken from next values
    // so a read right behind a write already sees the new contents
    always_comb begin
        logic acc;
        acc     = hsel_in & htrans_in[1] & hready_in;
        wr_d    = acc & hwrite_in;
        waddr_d = acc ? haddr_in[7:0] : waddr_q;
        rdata_d = rdata_q;
        if (acc && !hwrite_in) begin
            case (haddr_in[7:0])
                OFF_CTRL:  rdata_d = {26'h000_0000, ctrl_d};
                OFF_DIV:   rdata_d = (32'(rdiv_d) << DIV_R_POS) | 32'(ndiv_d);
                OFF_RANGE: rdata_d = (32'(exp_d) << RANGE_E_POS) | 32'(lin_d);
                OFF_STAT:  rdata_d = {30'h0000_0000, mode_d == MD_TRK, lock_d};
                OFF_ISTAT: rdata_d = {31'h0000_0000, ist_d};
                OFF_IMASK: rdata_d = {31'h0000_0000, imask_d};
                default:   rdata_d = RDATA_RST;
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            wr_q    <= 1'b0;
            waddr_q <= 8'h00;
            rdata_q <= RDATA_RST;
        end else if (ce_in) begin
            wr_q    <= wr_d;
            waddr_q <= waddr_d;
            rdata_q <= rdata_d;
        end
    end

    assign hreadyout_out = 1'b1;
    assign hresp_out     = 1'b0;
    assign hrdata_out    = rdata_q;

    ////////////////////////////////////////////////////////////////////////
    // configuration registers
    always_comb begin
        ctrl_d  = ctrl_q;
        ndiv_d  = ndiv_q;
        rdiv_d  = rdiv_q;
        lin_d   = lin_q;
        exp_d   = exp_q;
        imask_d = imask_q;
        if (wr_q) begin
            case (waddr_q)
                OFF_CTRL:  ctrl_d = hwdata_in[5:0];
                OFF_DIV: begin
                    ndiv_d = hwdata_in[NW-1:0];
                    rdiv_d = hwdata_in[DIV_R_POS +: NW];
                end
                OFF_RANGE: begin
                    lin_d = hwdata_in[7:0];
                    exp_d = hwdata_in[RANGE_E_POS +: 2];
                end
                OFF_IMASK: imask_d = hwdata_in[0];
                default:   ctrl_d = ctrl_q;
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            ctrl_q  <= CTRL_RST;
            ndiv_q  <= NW'(N_RST);
            rdiv_q  <= NW'(R_RST);
            lin_q   <= L_RST;
            exp_q   <= E_RST;
            imask_q <= 1'b0;
        end else if (ce_in) begin
            ctrl_q  <= ctrl_d;
            ndiv_q  <= ndiv_d;
            rdiv_q  <= rdiv_d;
            lin_q   <= lin_d;
            exp_q   <= exp_d;
            imask_q <= imask_d;
        end
    end

    assign vco_lin_out = lin_q;
    assign vco_exp_out = exp_q;

    ////////////////////////////////////////////////////////////////////////
    // clock dividers; clocks are sampled levels, so output rates are limited to half of clk_in
    // for the crystal copies and to a quarter of clk_in or less for the divided clocks
    assign x_re   = crystal_clock_in & ~xs_q;
    assign v_re   = vco_clock_in & ~vs_q & ctrl_q.pll_en;
    assign sel_re = ctrl_q.sel_vco ? v_re : x_re;

    always_comb begin
        base_d  = base_q ^ sel_re;
        bus_d   = bus_q ^ (sel_re & ~base_q);
        sys_d   = ctrl_q.sys_xtal ? crystal_clock_in : base_d;
        osc_d   = sysint_osc_enable_in | ctrl_q.run_stop;
        fbcnt_d = fbcnt_q;
        rfcnt_d = rfcnt_q;
        fbp_d   = 1'b0;
        rfp_d   = 1'b0;
        if (!ctrl_q.pll_en) begin
            fbcnt_d = '0;
            rfcnt_d = '0;
        end else begin
            if (v_re) begin
                if (fbcnt_q == div_top(ndiv_q)) begin
                    fbcnt_d = '0;
                    fbp_d   = 1'b1;
                end else begin
                    fbcnt_d = fbcnt_q + 1'b1;
                end
            end
            if (x_re) begin
                if (rfcnt_q == div_top(rdiv_q)) begin
                    rfcnt_d = '0;
                    rfp_d   = 1'b1;
                end else begin
                    rfcnt_d = rfcnt_q + 1'b1;
                end
            end
        end
        fbclk_d = ctrl_q.pll_en & (fbcnt_d == '0);
        rfclk_d = ctrl_q.pll_en & (rfcnt_d == '0);
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            xs_q    <= 1'b0;
            vs_q    <= 1'b0;
            base_q  <= 1'b0;
            bus_q   <= 1'b0;
            sys_q   <= 1'b0;
            osc_q   <= 1'b0;
            fbcnt_q <= '0;
            rfcnt_q <= '0;
            fbp_q   <= 1'b0;
            rfp_q   <= 1'b0;
            fbclk_q <= 1'b0;
            rfclk_q <= 1'b0;
        end else if (ce_in) begin
            xs_q    <= crystal_clock_in;
            vs_q    <= vco_clock_in;
            base_q  <= base_d;
            bus_q   <= bus_d;
            sys_q   <= sys_d;
            osc_q   <= osc_d;
            fbcnt_q <= fbcnt_d;
            rfcnt_q <= rfcnt_d;
            fbp_q   <= fbp_d;
            rfp_q   <= rfp_d;
            fbclk_q <= fbclk_d;
            rfclk_q <= rfclk_d;
        end
    end

    assign pll_reference_clock_out   = xs_q;
    assign final_reference_clock_out = rfclk_q;
    assign vco_feedback_clock_out    = fbclk_q;
    assign base_clock_out            = base_q;
    assign bus_clock_out             = bus_q;
    assign sys_clock_out             = sys_q;
    assign osc_enable_out            = osc_q;

    ////////////////////////////////////////////////////////////////////////
    // phase detector, lock detector, mode and lock interrupt
    // window counted in reference edges, so lock time follows the reference
    assign fsum = fcnt_q + LOCK_CW'(fbp_q);

    always_comb begin
        up_d   = ctrl_q.pll_en & (up_q | rfp_q);
        dn_d   = ctrl_q.pll_en & (dn_q | fbp_q);
        if (up_d && dn_d) begin
            up_d = 1'b0;
            dn_d = 1'b0;
        end
        win_d  = win_q;
        fcnt_d = (fsum == '1) ? fcnt_q : fsum;
        lock_d = lock_q;
        if (!ctrl_q.pll_en) begin
            win_d  = '0;
            fcnt_d = '0;
            lock_d = 1'b0;
        end else if (rfp_q) begin
            if (win_q == LOCK_CW'(LOCK_WIN - 1)) begin
                win_d  = '0;
                fcnt_d = '0;
                lock_d = (int'(fsum) >= LOCK_WIN - LOCK_TOL) && (int'(fsum) <= LOCK_WIN + LOCK_TOL);
            end else begin
                win_d = win_q + 1'b1;
            end
        end
        go_trk = ctrl_q.auto_md ? lock_d : ctrl_q.man_trk;
        case (mode_q)
            MD_ACQ:  mode_d = go_trk ? MD_TRK : MD_ACQ;
            MD_TRK:  mode_d = go_trk ? MD_TRK : MD_ACQ;
            default: mode_d = MD_ACQ;
        endcase
        ist_d = ist_q;
        if (wr_q && waddr_q == OFF_ISTAT && hwdata_in[0]) begin
            ist_d = 1'b0;
        end
        // a lock change in the clearing cycle must not be lost
        if (lock_d != lock_q) begin
            ist_d = 1'b1;
        end
        irq_d = ist_d & imask_d;
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            up_q   <= 1'b0;
            dn_q   <= 1'b0;
            win_q  <= '0;
            fcnt_q <= '0;
            lock_q <= 1'b0;
            mode_q <= MD_ACQ;
            ist_q  <= 1'b0;
            irq_q  <= 1'b0;
        end else if (ce_in) begin
            up_q   <= up_d;
            dn_q   <= dn_d;
            win_q  <= win_d;
            fcnt_q <= fcnt_d;
            lock_q <= lock_d;
            mode_q <= mode_d;
            ist_q  <= ist_d;
            irq_q  <= irq_d;
        end
    end

    assign pump_out     = '{fast: mode_q[0], up: up_q, dn: dn_q};
    assign locked_out   = lock_q;
    assign tracking_out = mode_q[1];
    assign irq_out      = irq_q;

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!arst_n_in);

    sequence s_range_wr;
        ce_in && wr_q && waddr_q == OFF_RANGE;
    endsequence

    sequence s_lock_move;
        ce_in && (lock_d != lock_q);
    endsequence

    AST_OSC_EN: assert property (ce_in |=> osc_enable_out == $past(sysint_osc_enable_in | ctrl_q.run_stop))
        else $error("oscillator enable wrong");
    AST_REF_COPY: assert property (ce_in |=> pll_reference_clock_out == $past(crystal_clock_in))
        else $error("reference clock is not the crystal copy");
    AST_BASE_SRC: assert property (ce_in && !sel_re |=> $stable(base_clock_out))
        else $error("base clock moved without selected edge");
    AST_BUS_HALF: assert property (ce_in && !(sel_re && !base_q) |=> $stable(bus_clock_out))
        else $error("bus clock moved without base rise");
    AST_SYS_SRC: assert property (ce_in |=> sys_clock_out ==
        ($past(ctrl_q.sys_xtal) ? $past(crystal_clock_in) : base_clock_out))
        else $error("system clock source wrong");
    AST_FB_DIV: assert property (ce_in && v_re && fbcnt_q == div_top(ndiv_q) |=> fbp_q && fbcnt_q == '0)
        else $error("feedback divider did not wrap");
    AST_PFD_UP: assert property (ce_in && ctrl_q.pll_en && rfp_q && !fbp_q && !dn_q
        |=> pump_out.up && !pump_out.dn)
        else $error("reference lead gave no up pulse");
    AST_LOCK_WIN: assert property (ce_in && ctrl_q.pll_en && !(rfp_q && win_q == LOCK_CW'(LOCK_WIN - 1))
        |=> $stable(lock_q))
        else $error("lock moved outside window end");
    AST_MODE_AUTO: assert property (ce_in && ctrl_q.auto_md |=> tracking_out == lock_q)
        else $error("automatic mode does not follow lock");
    AST_RANGE: assert property (s_range_wr |=> vco_lin_out == $past(hwdata_in[7:0])
        && vco_exp_out == $past(hwdata_in[9:8]))
        else $error("range write not applied");
    AST_LOCK_IRQ: assert property (s_lock_move |=> ist_q ##0 (irq_out == imask_q))
        else $error("lock change did not flag");

endmodule

/* File: testbench/cgu_osc_model.sv */
`timescale 1ns/1ps
module cgu_osc_model (
    input  wire logic       clk_in,
    input  wire logic       osc_enable_in,
    input  wire logic [7:0] xtal_half_in,
    input  wire logic [7:0] vco_half_in,
    output logic            crystal_clock_out,
    output logic            vco_clock_out
);
    int xcnt = 0;
    int vcnt = 0;
    initial begin
        crystal_clock_out = 1'b0;
        vco_clock_out     = 1'b0;
    end
    // crystal freezes while the amplifier is off; every level lasts at least two cycles
    always @(posedge clk_in) begin
        if (osc_enable_in) begin
            xcnt <= (xcnt + 1 >= xtal_half_in) ? 0 : xcnt + 1;
            if (xcnt + 1 >= xtal_half_in) begin
                crystal_clock_out <= ~crystal_clock_out;
            end
        end
        vcnt <= (vcnt + 1 >= vco_half_in) ? 0 : vcnt + 1;
        if (vcnt + 1 >= vco_half_in) begin
            vco_clock_out <= ~vco_clock_out;
        end
    end
endmodule

/* File: testbench/clock_generator_pll_control_tb_top.sv */
`timescale 1ns/1ps
module clock_generator_pll_control_tb_top;
    import cgu_pkg::*;
    logic        clk_in, arst_n_in, ce_in, hsel_in, hwrite_in, sysint_in, mon;
    logic [31:0] haddr_in, hwdata_in, hrdata, rd;
    logic [1:0]  htrans_in, ex;
    logic        hrdy, hresp, osc_en, pref, fref, fb, base, bus, sysc, locked, trk, irq, xtal, vco, psys, px;
    logic [7:0]  lin, xh, vh, l;
    logic [8:0]  sg, prv;
    cgu_pump_t   pump;
    int          errors, tests_run, seed, i, ctl;
    int          cnt[9] = '{default: 0};
    int          snap[9];
    int          d[9];
    // register model per word offset, starting from reset contents; wmsk marks software-writable bits
    int          mdl[$] = '{32'h0000_0004, 32'h0001_0001, 32'h0000_0001, 0, 0, 0, 0};
    int          wmsk[7] = '{32'h0000_003f, 32'h00ff_00ff, 32'h0000_03ff, 0, 0, 1, 0};

    cgu_top #(.NW(8), .LOCK_WIN(4), .LOCK_TOL(1)) dut (
        .clk_in(clk_in), .arst_n_in(arst_n_in), .ce_in(ce_in), .hsel_in(hsel_in), .haddr_in(haddr_in),
        .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(3'h2), .hwdata_in(hwdata_in),
        .hready_in(hrdy), .hreadyout_out(hrdy), .hresp_out(hresp), .hrdata_out(hrdata),
        .crystal_clock_in(xtal), .vco_clock_in(vco), .sysint_osc_enable_in(sysint_in),
        .osc_enable_out(osc_en), .pll_reference_clock_out(pref), .final_reference_clock_out(fref),
        .vco_feedback_clock_out(fb), .base_clock_out(base), .bus_clock_out(bus), .sys_clock_out(sysc),
        .pump_out(pump), .vco_lin_out(lin), .vco_exp_out(ex), .locked_out(locked),
        .tracking_out(trk), .irq_out(irq));

    cgu_osc_model u_osc (.clk_in(clk_in), .osc_enable_in(osc_en), .xtal_half_in(xh), .vco_half_in(vh),
        .crystal_clock_out(xtal), .vco_clock_out(vco));

    assign sg = {pump.dn, pump.up, fref, fb, sysc, bus, base, vco, xtal};

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] expv);
        tests_run++;
        if (seen !== expv) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", nm, expv, seen);
        end
    endtask

    // edge counts from sampled clocks may differ by one at the window borders
    task automatic cnear(input string nm, input int seen, input int ev);
        chk(nm, 32'((seen >= ev - 1 && seen <= ev + 1) ? ev : seen), 32'(ev));
    endtask

    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] r);
        logic tk;
        @(posedge clk_in);
        hsel_in   <= 1'b1;
        htrans_in <= 2'b10;
        haddr_in  <= {24'h00_0000, a};
        hwrite_in <= w;
        do @(posedge clk_in); while (hrdy !== 1'b1);
        // a request made while the clock enable is low is never taken
        tk = ce_in;
        htrans_in <= 2'b00;
        hwdata_in <= wd;
        do @(posedge clk_in); while (hrdy !== 1'b1);
        r = hrdata;
        if (w && tk && a < 8'h1c) begin
            mdl[a / 4] = (wd & wmsk[a / 4]) | (mdl[a / 4] & ~wmsk[a / 4]);
        end
        if (w && a == OFF_CTRL) begin
            ctl = wd;
        end
    endtask

    task automatic win(input int n);
        snap = cnt;
        repeat (n) @(posedge clk_in);
        foreach (d[k]) d[k] = cnt[k] - snap[k];
    endtask

    task automatic waitlock(input logic v);
        for (int k = 0; k < 600 && locked !== v; k++) @(posedge clk_in);
    endtask

    task automatic test_done;
        $display("errors=%0d tests_run=%0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    always @(posedge clk_in) begin
        for (int k = 0; k < 9; k++) if (sg[k] && !prv[k]) cnt[k] <= cnt[k] + 1;
        prv <= sg;
        if (mon) begin
            chk("osc enable", {31'h0, osc_en}, {31'h0, psys | ctl[4]});
            chk("pll reference", {31'h0, pref}, {31'h0, px});
        end
        psys <= sysint_in;
        px   <= xtal;
    end

    initial begin
        clk_in = 1'b0;
        forever #4 clk_in = ~clk_in;
    end

    initial begin
        repeat (20000) @(posedge clk_in);
        errors++;
        test_done();
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        seed = 32'h950e4090;
        {arst_n_in, hsel_in, hwrite_in, sysint_in, mon, prv} = '0;
        {haddr_in, hwdata_in, htrans_in} = '0;
        ce_in = 1'b1;
        ctl = 32'h0000_0004;
        xh = 8'h04;
        vh = 8'h02;
        errors = 0;
        tests_run = 0;
        repeat (3) @(posedge clk_in);
        arst_n_in <= 1'b1;
        for (i = 0; i < 7; i++) begin
            xfer(1'b0, 8'(i * 4), 0, rd);
            chk("reset value", rd, mdl[i]);
            chk("okay response", {31'h0, hresp}, 32'h0);
        end
        chk("lin reset", {24'h0, lin}, 32'h0000_0001);
        mon <= 1'b1;
        for (i = 0; i < 60; i++) begin
            @(posedge clk_in);
            sysint_in <= 1'($random(seed));
        end
        mon <= 1'b0;
        sysint_in <= 1'b1;
        xfer(1'b1, OFF_CTRL, 32'h0000_0014, rd);
        repeat (3) @(posedge clk_in);
        sysint_in <= 1'b0;
        mon <= 1'b1;
        win(400);
        mon <= 1'b0;
        cnear("base from crystal", d[2], d[0] / 2);
        cnear("bus from base", d[3], d[2] / 2);
        cnear("sys from base", d[4], d[2]);
        xfer(1'b1, OFF_CTRL, 32'h0000_0034, rd);
        win(200);
        cnear("sys from crystal", d[4], d[0]);
        for (i = 0; i < 3; i++) begin
            l = 8'($random(seed));
            xfer(1'b1, OFF_RANGE, {22'h0, 2'(i + 1), l}, rd);
            @(posedge clk_in);
            chk("vco linear", {24'h0, lin}, {24'h0, l});
            chk("vco exponent", {30'h0, ex}, 32'(i + 1));
        end
        ce_in <= 1'b0;
        xfer(1'b1, OFF_RANGE, 32'h0000_00ff, rd);
        ce_in <= 1'b1;
        xfer(1'b1, 8'h18, 32'h0000_0055, rd);
        xfer(1'b0, 8'h18, 0, rd);
        chk("unmapped", rd, 32'h0);
        xfer(1'b0, OFF_RANGE, 0, rd);
        chk("range kept", rd, {22'h0, 2'h3, l});
        chk("range model", rd, mdl[2]);
        xfer(1'b1, OFF_CTRL, 32'h0000_0017, rd);
        xfer(1'b1, OFF_DIV, 32'h0002_0003, rd);
        win(480);
        cnear("feedback", d[5], d[1] / 3);
        cnear("final reference", d[6], d[0] / 2);
        cnear("base from vco", d[2], d[1] / 2);
        xfer(1'b1, OFF_IMASK, 32'h0000_0001, rd);
        xfer(1'b1, OFF_DIV, 32'h0002_0004, rd);
        // let windows counted under the old divider drain so lock no longer moves
        repeat (200) @(posedge clk_in);
        waitlock(1'b1);
        chk("locked", {31'h0, locked}, 32'h1);
        xfer(1'b0, OFF_STAT, 0, rd);
        chk("status", rd, 32'h0000_0003);
        chk("acq off", {31'h0, pump.fast}, 32'h0);
        chk("irq lock", {31'h0, irq}, 32'h1);
        xfer(1'b1, OFF_ISTAT, 32'h0000_0001, rd);
        xfer(1'b0, OFF_ISTAT, 0, rd);
        chk("istat clear", rd, 32'h0);
        chk("irq clear", {31'h0, irq}, 32'h0);
        xfer(1'b1, OFF_CTRL, 32'h0000_0013, rd);
        repeat (2) @(posedge clk_in);
        chk("manual acq", {30'h0, trk, pump.fast}, 32'h1);
        xfer(1'b1, OFF_CTRL, 32'h0000_001b, rd);
        repeat (2) @(posedge clk_in);
        chk("manual trk", {30'h0, trk, pump.fast}, 32'h2);
        xfer(1'b1, OFF_CTRL, 32'h0000_0017, rd);
        xfer(1'b1, OFF_IMASK, 32'h0, rd);
        xfer(1'b1, OFF_DIV, 32'h0002_0008, rd);
        win(160);
        chk("pump raises", {31'h0, d[7] > d[8]}, 32'h1);
        waitlock(1'b0);
        xfer(1'b0, OFF_ISTAT, 0, rd);
        chk("unlock flag", rd, 32'h1);
        chk("irq masked", {31'h0, irq}, 32'h0);
        xfer(1'b1, OFF_IMASK, 32'h1, rd);
        repeat (2) @(posedge clk_in);
        chk("irq unmasked", {31'h0, irq}, 32'h1);
        test_done();
    end
endmodule
